// ### tb/test_usf_status_flags.sv
// test_usf_status_flags.sv: self-checking bench for the serial status block
// assumes: AHB-Lite master tasks here, frame model on the far side
`include "usf_cfg.svh"
module test_usf_status_flags
    import usf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ST = `USF_OFS_STATUS;
    localparam logic [7:0] C1 = `USF_OFS_CTRL1;
    localparam logic [7:0] C2 = `USF_OFS_CTRL2;
    localparam logic [7:0] DT = `USF_OFS_DATA;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rdata;
    logic        rxWordValid, rxParityBad, rxNoise, rxFrameBad, rxStartSeen, rxStopDone;
    logic        rxWordReady, txWordValid, txWordReady, txShifting;
    usf_byte_t   rxWordData, txWordData;
    logic        portEnable, transmitterEnable, receiverEnable, txBreak, parityEnable, rxIrq;
    logic [1:0]  parityType;
    int          miscompares = 0;
    int          cmpCount = 0;
    int          cycles = 0;
    always #50 clk = ~clk;
    usf_status_flags uut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxWordValid, .rxWordData,
        .rxParityBad, .rxNoise, .rxFrameBad, .rxStartSeen, .rxStopDone, .rxWordReady,
        .txWordValid, .txWordData, .txWordReady, .txShifting, .portEnable, .transmitterEnable,
        .receiverEnable, .txBreak, .parityEnable, .parityType, .rxIrq);
    usf_far_model farEnd (.clk, .rxWordValid, .rxWordData, .rxParityBad, .rxNoise, .rxFrameBad,
        .rxStartSeen, .rxStopDone, .rxWordReady, .txWordValid, .txWordData, .txWordReady,
        .txShifting);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        {hsel, htrans, haddr, hwrite} <= {1'b1, USF_NONSEQ, a, wr};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        {hsel, htrans, hwdata} <= {1'b0, USF_IDLE, wd};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdata = hrdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // cut a hang short well past the roughly 120 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = 3'h2;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(ST, 32'h0B);
        bus(1'b1, ST, 32'hFF);
        rdc(ST, 32'h0B);
        rdc(8'h20, 32'h0);
        bus(1'b1, C1, 32'h80);
        bus(1'b1, C2, 32'hC4);
        rdc(ST, 32'h0B);
        farEnd.startBit();
        rdc(ST, 32'h03);
        for (int t = 0; t < 5; t++) begin
            bus(1'b1, C1, (t < 4) ? 32'hA0 | (t << 3) : 32'h80);
            farEnd.send(8'h50 + t, 1'b1, 1'b0, 1'b0);
            check({29'h0, parityEnable, parityType}, (t < 4) ? 4 + t : 0);
            rdc(ST, (t < 4) ? 32'h8F : 32'h0F);
            check({31'h0, rxIrq}, 32'h1);
            rdc(DT, 32'h50 + t);
            rdc(ST, 32'h0B);
        end
        farEnd.send(8'hA1, 1'b0, 1'b0, 1'b1);
        farEnd.send(8'hA2, 1'b0, 1'b1, 1'b0);
        farEnd.send(8'hA3, 1'b0, 1'b1, 1'b0);
        rdc(DT, 32'hA1);
        rdc(ST, 32'h7F);
        rdc(DT, 32'hA2);
        rdc(ST, 32'h0B);
        farEnd.stall = 6;
        rdc(ST, 32'h0B);
        bus(1'b1, DT, 32'h3C);
        rdc(ST, 32'h08);
        while (!txShifting) @(posedge clk);
        rdc(ST, 32'h09);
        while (txShifting) @(posedge clk);
        rdc(ST, 32'h0B);
        check({24'h0, farEnd.lastTx}, 32'h3C);
        bus(1'b1, C1, 32'h84);
        rdc(ST, 32'h09);
        farEnd.send(8'hB0, 1'b0, 1'b0, 1'b1);
        bus(1'b1, C1, 32'h00);
        rdc(ST, 32'h0B);
        rdc(C2, 32'h04);
        end_sim();
    end
endmodule // test_usf_status_flags

// ### tb/usf_far_model.sv
// usf_far_model.sv: behavioural frame logic on both streams of the status block
// assumes: bench calls its tasks just after rising edges
module usf_far_model
    import usf_pkg::*;
(
    input  wire logic      clk,
    // receive stream
    output logic           rxWordValid,
    output usf_byte_t      rxWordData,
    output logic           rxParityBad,
    output logic           rxNoise,
    output logic           rxFrameBad,
    output logic           rxStartSeen,
    output logic           rxStopDone,
    input  wire logic      rxWordReady,
    // transmit stream
    input  wire logic      txWordValid,
    input  wire usf_byte_t txWordData,
    output logic           txWordReady,
    output logic           txShifting
);
    timeunit 1ns;
    timeprecision 1ns;
    int        stall = 0;
    int        waitCnt = 0;
    int        shiftLeft = 0;
    usf_byte_t lastTx = 8'h00;
    initial {rxWordValid, rxWordData, rxParityBad, rxNoise, rxFrameBad} = '0;
    initial {rxStartSeen, rxStopDone, txWordReady} = '0;
    assign txShifting = shiftLeft != 0;
    task automatic startBit();
        rxStartSeen <= 1'b1;
        @(posedge clk) rxStartSeen <= 1'b0;
    endtask
    // refused word held four cycles then lost, as a real receiver would
    task automatic send(input usf_byte_t d, input logic p, input logic n, input logic f);
        logic t;
        t = 1'b0;
        rxStopDone <= 1'b1;
        {rxWordValid, rxWordData, rxParityBad, rxNoise, rxFrameBad} <= {1'b1, d, p, n, f};
        for (int i = 0; i < 4 && !t; i++) begin
            @(negedge clk) t = rxWordReady;
            @(posedge clk) rxStopDone <= 1'b0;
        end
        // released lines show the inverse so a stale word cannot pass
        {rxWordValid, rxWordData, rxParityBad, rxNoise, rxFrameBad} <= {1'b0, ~d, 3'b000};
        // lines rest a cycle so the next word starts on a fresh edge
        @(posedge clk);
    endtask
    // stalls for stall cycles, then shifts each character for eight cycles
    always @(posedge clk) begin
        if (shiftLeft != 0) shiftLeft <= shiftLeft - 1;
        if (txWordValid && txWordReady) begin
            lastTx      <= txWordData;
            txWordReady <= 1'b0;
            shiftLeft   <= 8;
            waitCnt     <= 0;
        end else if (txWordValid && waitCnt >= stall) begin
            txWordReady <= 1'b1;
        end else if (txWordValid) begin
            waitCnt <= waitCnt + 1;
        end
    end
endmodule // usf_far_model

// ### tb/usf_status_flags_monitor.sv
// usf_status_flags_monitor.sv: port-level assertions for the serial status block
// assumes: bound to usf_status_flags, one clock, synchronous active-high reset
`include "usf_cfg.svh"
module usf_status_flags_chk
    import usf_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // register bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // transmit stream, settings and receive interrupt
    input wire logic        txWordValid,
    input wire usf_byte_t   txWordData,
    input wire logic        txWordReady,
    input wire logic        portEnable,
    input wire logic        transmitterEnable,
    input wire logic        receiverEnable,
    input wire logic        txBreak,
    input wire logic        rxIrq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire rdTake = hsel && hready && htrans[1] && !hwrite;
    wire wrData = hsel && hready && htrans[1] && hwrite && haddr == `USF_OFS_DATA;

    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_rdata_upper: assert property (hrdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_status_forced: assert property (
        rdTake && haddr == `USF_OFS_STATUS && !portEnable |=> hrdata == 32'h0B)
        else $error("status of disabled port not idle value");
    chk_unmapped_zero: assert property (rdTake && haddr > `USF_OFS_DATA |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_disable_clears: assert property (
        $fell(portEnable) |=> !transmitterEnable && !receiverEnable && !txBreak)
        else $error("port disable left enables set");
    chk_irq_gated: assert property (!portEnable && !$past(portEnable) |-> !rxIrq)
        else $error("receive interrupt while port disabled");
    chk_tx_load: assert property (
        wrData && portEnable && transmitterEnable
        |=> ##1 (txWordValid && txWordData == $past(hwdata[7:0])))
        else $error("data write did not fill transmit hold");
    chk_tx_hold: assert property (
        txWordValid && !txWordReady && !$past(wrData)
        |=> txWordValid && $stable(txWordData) || !transmitterEnable || !portEnable)
        else $error("transmit hold changed before taken");
    chk_tx_taken: assert property (txWordValid && txWordReady && !$past(wrData) |=> !txWordValid)
        else $error("transmit hold not emptied when taken");
endmodule // usf_status_flags_chk

bind usf_status_flags usf_status_flags_chk chk (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .txWordValid, .txWordData, .txWordReady,
    .portEnable, .transmitterEnable, .receiverEnable, .txBreak, .rxIrq);

// ### verilog/usf_cfg.svh
// usf_cfg.svh: offsets, bit positions and reset values of the serial status block
// assumes: included by bare name from the design file, the test bench and the monitor
`ifndef USF_CFG_SVH
`define USF_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define USF_OFS_STATUS   8'h00
`define USF_OFS_CTRL1    8'h04
`define USF_OFS_CTRL2    8'h08
`define USF_OFS_CTRL3    8'h0C
`define USF_OFS_DATA     8'h10
// ----------------------------------------
// line_status bit positions
// ----------------------------------------
`define USF_B_PERR       7
`define USF_B_NOISE      6
`define USF_B_FERR       5
`define USF_B_OERR       4
`define USF_B_RXIDLE     3
`define USF_B_RXRDY      2
`define USF_B_TXIDLE     1
`define USF_B_TXEMPTY    0
// ----------------------------------------
// control bit positions
// ----------------------------------------
`define USF_B_PORTEN     7
`define USF_B_PAREN      5
`define USF_B_PTYPE_HI   4
`define USF_B_PTYPE_LO   3
`define USF_B_BREAK      2
`define USF_B_TXEN       7
`define USF_B_RXEN       6
`define USF_B_RIE        2
// ----------------------------------------
// reset values and receive buffer depth
// ----------------------------------------
`define USF_RST_STATUS   8'h0B
`define USF_RST_CTRL     8'h00
`define USF_RXBUF_DEPTH  2'h2
`endif

// ### verilog/usf_pkg.sv
// usf_pkg.sv: types shared by the serial status block
// assumes: usf_cfg.svh holds every register number; the bus transfer codes stand here
package usf_pkg;
    typedef logic [7:0] usf_byte_t;
    typedef enum logic [1:0] {
        USF_IDLE   = 2'b00,
        USF_BUSY   = 2'b01,
        USF_NONSEQ = 2'b10,
        USF_SEQ    = 2'b11
    } usf_htrans_t;
endpackage

// ### verilog/usf_status_flags.sv
// usf_status_flags.sv: flags, shared data path and AHB-Lite registers of a serial port
// assumes: frame logic outside shifts bits, reports word events; one 10 MHz clock
`include "usf_cfg.svh"

module usf_status_flags
    import usf_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // receive frame logic
    input  wire logic        rxWordValid,
    input  wire usf_byte_t   rxWordData,
    input  wire logic        rxParityBad,
    input  wire logic        rxNoise,
    input  wire logic        rxFrameBad,
    input  wire logic        rxStartSeen,
    input  wire logic        rxStopDone,
    output logic             rxWordReady,
    // transmit shifter
    output logic             txWordValid,
    output usf_byte_t        txWordData,
    input  wire logic        txWordReady,
    input  wire logic        txShifting,
    // settings to frame logic, and the receive interrupt
    output logic             portEnable,
    output logic             transmitterEnable,
    output logic             receiverEnable,
    output logic             txBreak,
    output logic             parityEnable,
    output logic [1:0]       parityType,
    output logic             rxIrq
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    usf_byte_t   ctrl1_ff;
    usf_byte_t   ctrl2_ff;
    logic        ctrl3_ff;
    logic        perr_ff;
    logic        noise_ff;
    logic        ferr_ff;
    logic        oerr_ff;
    logic        rxIdle_ff;
    logic        rxRdy_ff;
    logic        txIdle_ff;
    logic        txEmpty_ff;
    usf_byte_t   arm_ff;
    usf_byte_t   rxBuf_ff [0:1];
    logic        rxWr_ff;
    logic        rxRd_ff;
    logic [1:0]  rxCnt_ff;
    logic        rxAccept_ff;
    usf_byte_t   txHold_ff;
    logic        txFull_ff;
    logic        wrPend_ff;
    logic [7:0]  wrAddr_ff;
    logic [31:0] hrdata_ff;
    logic        rxIrq_ff;
    logic        hreadyout_ff;
    logic        hresp_ff;
    // flag values of reset and of a disabled port
    localparam usf_byte_t flagRst = `USF_RST_STATUS;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire         addrPhase  = hsel && hready && htrans[1];
    wire         rdPhase    = addrPhase && !hwrite;
    wire         stRead     = rdPhase && (haddr == `USF_OFS_STATUS);
    wire         dataRead   = rdPhase && (haddr == `USF_OFS_DATA);
    // writes act in the data phase, when hwdata stands on the bus
    wire         wrData     = wrPend_ff && (wrAddr_ff == `USF_OFS_DATA);
    wire         wrCtrl1    = wrPend_ff && (wrAddr_ff == `USF_OFS_CTRL1);
    wire         wrCtrl2    = wrPend_ff && (wrAddr_ff == `USF_OFS_CTRL2);
    wire         wrCtrl3    = wrPend_ff && (wrAddr_ff == `USF_OFS_CTRL3);
    wire         dataAccess = dataRead || wrData;
    wire         portOn     = ctrl1_ff[`USF_B_PORTEN];
    wire         txOn       = portOn && ctrl2_ff[`USF_B_TXEN];
    wire         rxOn       = portOn && ctrl2_ff[`USF_B_RXEN];
    wire usf_byte_t wrByte  = hwdata[7:0];

    // a disabled port reads as idle even in the cycle it turns off
    wire usf_byte_t flagBits = {perr_ff, noise_ff, ferr_ff, oerr_ff,
                                rxIdle_ff, rxRdy_ff, txIdle_ff, txEmpty_ff};
    wire usf_byte_t status   = portOn ? flagBits : flagRst;
    wire usf_byte_t rxHead = rxBuf_ff[rxRd_ff];

    wire usf_byte_t rdMux =
        (haddr == `USF_OFS_STATUS) ? status :
        (haddr == `USF_OFS_CTRL1)  ? ctrl1_ff :
        (haddr == `USF_OFS_CTRL2)  ? ctrl2_ff :
        (haddr == `USF_OFS_CTRL3)  ? {7'h00, ctrl3_ff} :
        (haddr == `USF_OFS_DATA)   ? rxHead : 8'h00;

    // ----------------------------------------
    // receive buffer, two entries
    // ----------------------------------------
    // ready comes from a flop, so it reflects last cycle's room; an
    // overrun word is dropped, never written over a buffered one
    wire rxPush     = rxWordValid && rxAccept_ff;
    wire rxOverflow = rxOn && rxWordValid && !rxAccept_ff && !oerr_ff;
    wire rxPop      = dataRead && (rxCnt_ff != 2'h0);
    wire [1:0] nxt_rxCnt = rxCnt_ff + {1'b0, rxPush} - {1'b0, rxPop};
    wire rxLastOut  = rxPop && !rxPush && (rxCnt_ff == 2'h1);

    // ----------------------------------------
    // arming and clearing
    // ----------------------------------------
    // a status read arms each flag it saw set; armed bits are used and
    // dropped by the next shared data access
    wire usf_byte_t nxt_arm = stRead ? (arm_ff | status) :
                              (dataAccess ? 8'h00 : arm_ff);
    wire errClrPerr  = dataAccess && arm_ff[`USF_B_PERR];
    wire errClrNoise = dataAccess && arm_ff[`USF_B_NOISE];
    wire errClrFerr  = dataAccess && arm_ff[`USF_B_FERR];
    wire errClrOerr  = dataAccess && arm_ff[`USF_B_OERR];
    wire rdyClr   = dataRead && arm_ff[`USF_B_RXRDY] && rxLastOut;
    wire idleClr  = wrData && arm_ff[`USF_B_TXIDLE];
    wire emptyClr = wrData && arm_ff[`USF_B_TXEMPTY];

    // ----------------------------------------
    // flag set terms
    // ----------------------------------------
    wire setPerr  = rxPush && rxParityBad && parityEnable;
    wire setNoise = rxPush && rxNoise;
    wire setFerr  = rxPush && rxFrameBad;
    wire txTake   = txFull_ff && txWordReady;
    // a break written this cycle already counts, so idle drops with the write
    wire breakNow = wrCtrl1 ? wrByte[`USF_B_BREAK] : ctrl1_ff[`USF_B_BREAK];
    wire txQueued = txFull_ff || wrData || breakNow;
    wire setIdle  = txEmpty_ff && !txShifting && !txQueued;

    // set wins over a clear landing in the same cycle
    function automatic logic flagNext(input logic setEv, input logic curVal,
                                      input logic clrEv);
        return setEv || (curVal && !clrEv);
    endfunction

    wire nxt_perr  = flagNext(setPerr, perr_ff, errClrPerr);
    wire nxt_noise = flagNext(setNoise, noise_ff, errClrNoise);
    wire nxt_ferr  = flagNext(setFerr, ferr_ff, errClrFerr);
    wire nxt_oerr  = flagNext(rxOverflow, oerr_ff, errClrOerr);
    wire nxt_rdy   = flagNext(rxPush, rxRdy_ff, rdyClr);
    wire nxt_empty = txTake || !txOn ||
                     (txEmpty_ff && !emptyClr);
    wire nxt_idle  = (setIdle || txIdle_ff) && !idleClr && !txQueued;
    wire nxt_rxIdle = rxStopDone ? 1'b1 :
                      (rxStartSeen ? 1'b0 : rxIdle_ff);

    // ----------------------------------------
    // bus pipeline
    // ----------------------------------------
    // read data is caught at the address edge and stands through the data phase
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_ff <= 1'b0;
            wrAddr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
        end else begin
            wrPend_ff <= addrPhase && hwrite;
            wrAddr_ff <= addrPhase ? haddr : wrAddr_ff;
            hrdata_ff <= rdPhase ? {24'h00_0000, rdMux} : hrdata_ff;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // disabling the port drops the enables and break; other settings stay
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl1_ff <= `USF_RST_CTRL;
            ctrl2_ff <= `USF_RST_CTRL;
            ctrl3_ff <= 1'b0;
        end else begin
            if (wrCtrl1)
                ctrl1_ff <= wrByte;
            else if (!portOn)
                ctrl1_ff[`USF_B_BREAK] <= 1'b0;
            if (wrCtrl2)
                ctrl2_ff <= wrByte;
            else if (!portOn)
                ctrl2_ff[`USF_B_TXEN:`USF_B_RXEN] <= 2'b00;
            if (wrCtrl3)
                ctrl3_ff <= wrByte[0];
        end
    end

    // ----------------------------------------
    // status flags
    // ----------------------------------------
    // a disabled port holds every flag at its idle value
    always_ff @(posedge clk) begin
        if (rst || !portOn) begin
            perr_ff  <= flagRst[`USF_B_PERR];
            noise_ff <= flagRst[`USF_B_NOISE];
            ferr_ff  <= flagRst[`USF_B_FERR];
            oerr_ff  <= flagRst[`USF_B_OERR];
        end else begin
            perr_ff  <= nxt_perr;
            noise_ff <= nxt_noise;
            ferr_ff  <= nxt_ferr;
            oerr_ff  <= nxt_oerr;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !portOn) begin
            rxIdle_ff <= flagRst[`USF_B_RXIDLE];
            rxRdy_ff  <= flagRst[`USF_B_RXRDY];
        end else begin
            rxIdle_ff <= nxt_rxIdle;
            rxRdy_ff  <= nxt_rdy;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || !portOn) begin
            txIdle_ff  <= flagRst[`USF_B_TXIDLE];
            txEmpty_ff <= flagRst[`USF_B_TXEMPTY];
        end else begin
            txIdle_ff  <= nxt_idle;
            txEmpty_ff <= nxt_empty;
        end
    end

    // arms never outlive a disable
    always_ff @(posedge clk) begin
        if (rst || !portOn)
            arm_ff <= 8'h00;
        else
            arm_ff <= nxt_arm;
    end

    // ----------------------------------------
    // receive data path
    // ----------------------------------------
    // buffer words carry no reset; a data read returns the head entry even when none is counted
    always_ff @(posedge clk) begin
        if (rxPush)
            rxBuf_ff[rxWr_ff] <= rxWordData;
    end

    always_ff @(posedge clk) begin
        if (rst || !rxOn) begin
            rxWr_ff     <= 1'b0;
            rxRd_ff     <= 1'b0;
            rxCnt_ff    <= 2'h0;
            rxAccept_ff <= 1'b0;
        end else begin
            rxWr_ff     <= rxWr_ff ^ rxPush;
            rxRd_ff     <= rxRd_ff ^ rxPop;
            rxCnt_ff    <= nxt_rxCnt;
            rxAccept_ff <= (nxt_rxCnt != `USF_RXBUF_DEPTH) && !nxt_oerr;
        end
    end

    // ----------------------------------------
    // transmit holding register
    // ----------------------------------------
    // a write while still full replaces the queued character
    always_ff @(posedge clk) begin
        if (rst || !txOn) begin
            txHold_ff <= 8'h00;
            txFull_ff <= 1'b0;
        end else begin
            txHold_ff <= wrData ? wrByte : txHold_ff;
            txFull_ff <= wrData || (txFull_ff && !txWordReady);
        end
    end

    // ----------------------------------------
    // receive interrupt
    // ----------------------------------------
    // a level that changes on the same edge as the ready flag
    always_ff @(posedge clk) begin
        if (rst)
            rxIrq_ff <= 1'b0;
        else
            rxIrq_ff <= nxt_rdy && ctrl2_ff[`USF_B_RIE] && portOn;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // bus answer comes from flops as well: no wait states, always okay
    always_ff @(posedge clk) begin
        if (rst) begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end else begin
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
        end
    end

    assign hrdata            = hrdata_ff;
    assign hreadyout         = hreadyout_ff;
    assign hresp             = hresp_ff;
    assign rxWordReady       = rxAccept_ff;
    assign txWordValid       = txFull_ff;
    assign txWordData        = txHold_ff;
    assign portEnable        = ctrl1_ff[`USF_B_PORTEN];
    assign transmitterEnable = ctrl2_ff[`USF_B_TXEN];
    assign receiverEnable    = ctrl2_ff[`USF_B_RXEN];
    assign txBreak           = ctrl1_ff[`USF_B_BREAK];
    assign parityEnable      = ctrl1_ff[`USF_B_PAREN];
    assign parityType        = ctrl1_ff[`USF_B_PTYPE_HI:`USF_B_PTYPE_LO];
    assign rxIrq             = rxIrq_ff;

endmodule // usf_status_flags
